// ### rtl/twm_defines.svh
// offsets, field positions, reset values, codes and timing counts
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// register offsets on the plain register port
`define TWM_REG_CTRL 2'h0
`define TWM_REG_STATUS 2'h1
`define TWM_REG_DATA 2'h2

// control register bit positions
`define TWM_CTRL_FLAG 7
`define TWM_CTRL_START 5
`define TWM_CTRL_STOP 4
`define TWM_CTRL_EN 2
`define TWM_CTRL_IE 0

// status codes
`define TWM_ST_NONE 8'hf8
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_ADDR_ACK 8'h18
`define TWM_ST_ADDR_NACK 8'h20
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_LOST_ADDR 8'h68

// reset values
`define TWM_RST_BYTE 8'h00
`define TWM_RST_OWN_ADDR 7'h2a
`define TWM_RST_PEER_ADDR 7'h50

// timing: half period of the generated bus clock
`define TWM_CLK_MHZ 40
`define TWM_HALF_NS 2500
`define TWM_HALF_CYC ((`TWM_HALF_NS * `TWM_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/twm_pkg.sv
// types shared by both ends of the two-wire link
package twm_pkg;

    typedef enum logic [3:0] {
        M_IDLE,
        M_START,
        M_HOLD,
        M_RS_LOW,
        M_RS_HIGH,
        M_LOW,
        M_HIGH,
        M_STOP_LOW,
        M_STOP_HIGH
    } twm_mst_state_t;

    typedef enum logic [1:0] {
        P_IDLE,
        P_BITS,
        P_ACK,
        P_SKIP
    } twm_peer_state_t;

endpackage

// ### rtl/twm_bus_if.sv
// wired-and clock and data lines joining the two ends
`timescale 1ns/1ps
interface twm_bus_if;
    // per party: output level (always low) and enable, high while driving
    logic dev_scl_out;
    logic dev_scl_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic far_scl_out;
    logic far_scl_oe;
    logic far_sda_out;
    logic far_sda_oe;
    // extra pull-downs the bench may use as further masters
    logic bench_scl_low;
    logic bench_sda_low;
    logic scl_line;
    logic sda_line;

    // open drain: any enabled low driver wins, else the pull-up
    assign scl_line = !(dev_scl_oe && !dev_scl_out) &&
                      !(far_scl_oe && !far_scl_out) &&
                      !(bench_scl_low === 1'b1);
    assign sda_line = !(dev_sda_oe && !dev_sda_out) &&
                      !(far_sda_oe && !far_sda_out) &&
                      !(bench_sda_low === 1'b1);

    modport dev (
        input scl_line,
        input sda_line,
        output dev_scl_out,
        output dev_scl_oe,
        output dev_sda_out,
        output dev_sda_oe
    );

    modport far (
        input scl_line,
        input sda_line,
        output far_scl_out,
        output far_scl_oe,
        output far_sda_out,
        output far_sda_oe
    );
endinterface

// ### rtl/twm_master.sv
// two-wire bus master with clock sync, arbitration and byte handshake
//
// Notes on behaviour
// - bus clock is the wired-and of all masters
// - phase timing starts when the line really changes
// - sample data after driving; mismatch loses arbitration
// - only a released-high bit can lose
// - on loss, drop to slave and check address
// - loser releases data, clocks to packet end
// - arbitration runs bit by bit into data
// - data changes only while clock is low
// - software keeps all transfers the same shape
// - flag rises after every bus event except a stop
// - interrupt needs flag, block and global enable
// - status code valid while flag is set
// - writing one to the flag clears it
// - nothing starts until software clears the flag
// - start request sends start, then start code
// - one byte register holds address and data
// - address packet done sets flag, ack code
// - data packet done sets flag, ack code
// - software loads address, then clears flag
// - clock held low while flag is set, but released after a loss
// - stop is sent without raising the flag
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_master #(
    parameter int HALF_CYC = `TWM_HALF_CYC,
    parameter logic [6:0] OWN_ADDR = `TWM_RST_OWN_ADDR
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // interrupt request
    input wire logic global_irq_enable_in,
    output logic irq_out,
    // two-wire link
    twm_bus_if.dev bus
);

    ////////////////////////////////////////////////////////////////////////
    twm_pkg::twm_mst_state_t state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] status_ff, nxt_status;
    logic flag_ff, nxt_flag;
    logic start_req_ff, nxt_start_req;
    logic stop_req_ff, nxt_stop_req;
    logic en_ff, nxt_en;
    logic ie_ff, nxt_ie;
    logic lost_ff, nxt_lost;
    logic addr_pkt_ff, nxt_addr_pkt;
    logic busy_ff, nxt_busy;
    logic ack_ff, nxt_ack;
    logic sampled_ff, nxt_sampled;
    logic scl_oe_ff, nxt_scl_oe;
    logic sda_oe_ff, nxt_sda_oe;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic set_flag;
    logic [7:0] set_code;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire scl_hi = scl_sync_ff[1];
    wire sda_hi = sda_sync_ff[1];
    wire ctrl_wr = reg_wr_in && (reg_addr_in == `TWM_REG_CTRL);
    wire data_wr = reg_wr_in && (reg_addr_in == `TWM_REG_DATA);
    wire flag_clr = ctrl_wr && reg_wdata_in[`TWM_CTRL_FLAG];
    wire cnt_done = (cnt_ff == 16'(HALF_CYC - 1));
    wire data_bit = (bit_ff < 4'h8);
    // drive low only for a zero data bit, never after a loss
    wire drive_low = data_bit && !lost_ff && !shift_ff[7];
    wire shifting = (state_ff != twm_pkg::M_IDLE) &&
                    (state_ff != twm_pkg::M_HOLD);
    wire addressed = (shift_ff[7:1] == OWN_ADDR);
    wire [7:0] ctrl_view = {flag_ff, 1'b0, start_req_ff, stop_req_ff,
                            1'b0, en_ff, 1'b0, ie_ff};
    wire [7:0] read_mux = (reg_addr_in == `TWM_REG_CTRL) ? ctrl_view :
                          (reg_addr_in == `TWM_REG_STATUS) ? status_ff :
                          (reg_addr_in == `TWM_REG_DATA) ? shift_ff :
                          8'h00;

    ////////////////////////////////////////////////////////////////////////
    // bus engine
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_shift = shift_ff;
        nxt_start_req = start_req_ff;
        nxt_stop_req = stop_req_ff;
        nxt_en = en_ff;
        nxt_ie = ie_ff;
        nxt_lost = lost_ff;
        nxt_addr_pkt = addr_pkt_ff;
        nxt_busy = busy_ff;
        nxt_ack = ack_ff;
        nxt_sampled = sampled_ff;
        nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;
        set_flag = 1'b0;
        set_code = status_ff;
        case (state_ff)
            twm_pkg::M_IDLE: begin
                nxt_scl_oe = 1'b0;
                nxt_sda_oe = 1'b0;
                if (en_ff && !flag_ff && start_req_ff && scl_hi &&
                    sda_hi) begin
                    nxt_state = twm_pkg::M_START;
                    nxt_cnt = 16'h0000;
                end
            end
            twm_pkg::M_START: begin
                nxt_sda_oe = 1'b1;
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_done) begin
                    nxt_scl_oe = 1'b1;
                    nxt_state = twm_pkg::M_HOLD;
                    nxt_start_req = 1'b0;
                    nxt_addr_pkt = 1'b1;
                    nxt_lost = 1'b0;
                    nxt_busy = 1'b1;
                    set_flag = 1'b1;
                    set_code = busy_ff ? `TWM_ST_RSTART : `TWM_ST_START;
                end
            end
            twm_pkg::M_HOLD: begin
                nxt_scl_oe = 1'b1;
                nxt_cnt = 16'h0000;
                if (!flag_ff) begin
                    if (start_req_ff) begin
                        nxt_state = twm_pkg::M_RS_LOW;
                    end else if (stop_req_ff) begin
                        nxt_sda_oe = 1'b1;
                        nxt_state = twm_pkg::M_STOP_LOW;
                    end else begin
                        nxt_bit = 4'h0;
                        nxt_state = twm_pkg::M_LOW;
                    end
                end
            end
            twm_pkg::M_RS_LOW: begin
                nxt_sda_oe = 1'b0;
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_done) begin
                    nxt_scl_oe = 1'b0;
                    nxt_cnt = 16'h0000;
                    nxt_state = twm_pkg::M_RS_HIGH;
                end
            end
            twm_pkg::M_RS_HIGH: begin
                if (scl_hi) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (cnt_done) begin
                        nxt_cnt = 16'h0000;
                        nxt_state = twm_pkg::M_START;
                    end
                end
            end
            twm_pkg::M_LOW: begin
                nxt_sda_oe = drive_low;
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_done) begin
                    nxt_scl_oe = 1'b0;
                    nxt_cnt = 16'h0000;
                    nxt_sampled = 1'b0;
                    nxt_state = twm_pkg::M_HIGH;
                end
            end
            twm_pkg::M_HIGH: begin
                // high time counts only once the line is seen high
                if (scl_hi) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (!sampled_ff) begin
                        nxt_sampled = 1'b1;
                        if (data_bit) begin
                            nxt_shift = {shift_ff[6:0], sda_hi};
                            if (!sda_oe_ff && !sda_hi) begin
                                nxt_lost = 1'b1;
                            end
                        end else begin
                            nxt_ack = !sda_hi;
                        end
                    end
                end
                // a faster master pulling low ends our high phase early
                if ((scl_hi && cnt_done) ||
                    (!scl_hi && sampled_ff)) begin
                    nxt_scl_oe = 1'b1;
                    nxt_cnt = 16'h0000;
                    if (data_bit) begin
                        nxt_bit = bit_ff + 4'h1;
                        nxt_state = twm_pkg::M_LOW;
                    end else if (lost_ff) begin
                        // slave side: release clock, report loss, with the addressed code if addressed
                        nxt_scl_oe = 1'b0;
                        nxt_sda_oe = 1'b0;
                        nxt_busy = 1'b0;
                        nxt_addr_pkt = 1'b0;
                        nxt_state = twm_pkg::M_IDLE;
                        set_flag = 1'b1;
                        set_code = (addr_pkt_ff && addressed) ?
                                   `TWM_ST_LOST_ADDR : `TWM_ST_LOST;
                    end else begin
                        nxt_sda_oe = 1'b0;
                        nxt_addr_pkt = 1'b0;
                        nxt_state = twm_pkg::M_HOLD;
                        set_flag = 1'b1;
                        if (addr_pkt_ff) begin
                            set_code = nxt_ack ? `TWM_ST_ADDR_ACK :
                                                 `TWM_ST_ADDR_NACK;
                        end else begin
                            set_code = nxt_ack ? `TWM_ST_DATA_ACK :
                                                 `TWM_ST_DATA_NACK;
                        end
                    end
                end
            end
            twm_pkg::M_STOP_LOW: begin
                nxt_sda_oe = 1'b1;
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_done) begin
                    nxt_scl_oe = 1'b0;
                    nxt_cnt = 16'h0000;
                    nxt_state = twm_pkg::M_STOP_HIGH;
                end
            end
            twm_pkg::M_STOP_HIGH: begin
                if (scl_hi) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (cnt_done) begin
                        // stop leaves the flag alone
                        nxt_sda_oe = 1'b0;
                        nxt_stop_req = 1'b0;
                        nxt_busy = 1'b0;
                        nxt_state = twm_pkg::M_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = twm_pkg::M_IDLE;
            end
        endcase
        if (ctrl_wr) begin
            nxt_start_req = reg_wdata_in[`TWM_CTRL_START];
            nxt_stop_req = reg_wdata_in[`TWM_CTRL_STOP];
            nxt_en = reg_wdata_in[`TWM_CTRL_EN];
            nxt_ie = reg_wdata_in[`TWM_CTRL_IE];
        end
        // writes during a packet would corrupt the byte on the wire
        if (data_wr && !shifting) begin
            nxt_shift = reg_wdata_in;
        end
    end

    // a set in the clearing cycle wins
    assign nxt_flag = set_flag || (flag_ff && !flag_clr);
    assign nxt_status = set_flag ? set_code : status_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], bus.scl_line};
            sda_sync_ff <= {sda_sync_ff[0], bus.sda_line};
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= twm_pkg::M_IDLE;
            cnt_ff <= 16'h0000;
            bit_ff <= 4'h0;
            shift_ff <= `TWM_RST_BYTE;
            status_ff <= `TWM_ST_NONE;
            flag_ff <= 1'b0;
            start_req_ff <= 1'b0;
            stop_req_ff <= 1'b0;
            en_ff <= 1'b0;
            ie_ff <= 1'b0;
            lost_ff <= 1'b0;
            addr_pkt_ff <= 1'b0;
            busy_ff <= 1'b0;
            ack_ff <= 1'b0;
            sampled_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            status_ff <= nxt_status;
            flag_ff <= nxt_flag;
            start_req_ff <= nxt_start_req;
            stop_req_ff <= nxt_stop_req;
            en_ff <= nxt_en;
            ie_ff <= nxt_ie;
            lost_ff <= nxt_lost;
            addr_pkt_ff <= nxt_addr_pkt;
            busy_ff <= nxt_busy;
            ack_ff <= nxt_ack;
            sampled_ff <= nxt_sampled;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            rdata_ff <= reg_rd_in ? read_mux : 8'h00;
            irq_ff <= flag_ff && ie_ff && global_irq_enable_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata_out = rdata_ff;
    assign irq_out = irq_ff;
    assign bus.dev_scl_out = 1'b0;
    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_scl_oe = scl_oe_ff;
    assign bus.dev_sda_oe = sda_oe_ff;

endmodule

// ### rtl/twm_peer.sv
// addressed slave on the far side: acknowledges its address and bytes
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_peer #(
    parameter logic [6:0] PEER_ADDR = `TWM_RST_PEER_ADDR
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // received bytes
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic selected_out,
    // two-wire link
    twm_bus_if.far bus
);

    ////////////////////////////////////////////////////////////////////////
    twm_pkg::twm_peer_state_t state_ff;
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic [3:0] bit_ff;
    logic [7:0] shift_ff;
    logic addr_phase_ff;
    logic sel_ff;
    logic sda_oe_ff;
    logic [7:0] rx_data_ff;
    logic rx_valid_ff;

    wire scl_hi = scl_sync_ff[1];
    wire sda_hi = sda_sync_ff[1];
    wire scl_rise = scl_hi && !scl_prev_ff;
    wire scl_fall = !scl_hi && scl_prev_ff;
    wire start_seen = scl_hi && scl_prev_ff && sda_prev_ff && !sda_hi;
    wire stop_seen = scl_hi && scl_prev_ff && !sda_prev_ff && sda_hi;
    wire addr_match = (shift_ff[7:1] == PEER_ADDR);
    wire want_ack = addr_phase_ff ? addr_match : sel_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], bus.scl_line};
            sda_sync_ff <= {sda_sync_ff[0], bus.sda_line};
            scl_prev_ff <= scl_hi;
            sda_prev_ff <= sda_hi;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= twm_pkg::P_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= `TWM_RST_BYTE;
            addr_phase_ff <= 1'b0;
            sel_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            rx_data_ff <= `TWM_RST_BYTE;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (start_seen) begin
                state_ff <= twm_pkg::P_BITS;
                bit_ff <= 4'h0;
                addr_phase_ff <= 1'b1;
                sel_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
            end else if (stop_seen) begin
                state_ff <= twm_pkg::P_IDLE;
                sel_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    twm_pkg::P_BITS: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_hi};
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_fall && bit_ff == 4'h8) begin
                            // ack pulled only while the clock is low
                            sda_oe_ff <= want_ack;
                            state_ff <= want_ack ? twm_pkg::P_ACK :
                                                   twm_pkg::P_SKIP;
                        end
                    end
                    twm_pkg::P_ACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            bit_ff <= 4'h0;
                            addr_phase_ff <= 1'b0;
                            state_ff <= twm_pkg::P_BITS;
                            if (addr_phase_ff) begin
                                sel_ff <= 1'b1;
                            end else begin
                                rx_data_ff <= shift_ff;
                                rx_valid_ff <= 1'b1;
                            end
                        end
                    end
                    twm_pkg::P_SKIP: begin
                        sda_oe_ff <= 1'b0;
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rx_data_out = rx_data_ff;
    assign rx_valid_out = rx_valid_ff;
    assign selected_out = sel_ff;
    assign bus.far_scl_out = 1'b0;
    assign bus.far_sda_out = 1'b0;
    assign bus.far_scl_oe = 1'b0;
    assign bus.far_sda_oe = sda_oe_ff;

endmodule

// ### tb/twm_monitor.sv
// checker of the two-wire lines between the master and the peer
`timescale 1ns/1ps
module twm_monitor (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // link signals
    input wire logic scl_line,
    input wire logic sda_line,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic far_sda_oe,
    input wire logic bench_sda_low
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!resetn_in);
////////////////////////////////////////////////////////////////////////////
property p_ack_on; $rose(far_sda_oe) |-> !scl_line; endproperty
a_ack_on: assert property (p_ack_on) else $error("ack set in high");
property p_ack_off; $fell(far_sda_oe) |-> !scl_line; endproperty
a_ack_off: assert property (p_ack_off) else $error("ack off in high");
property p_start; $rose(dev_sda_oe) && scl_line |-> ##[6:10] dev_scl_oe;
endproperty
a_start: assert property (p_start) else $error("start not framed");
property p_low; $rose(dev_scl_oe) |-> dev_scl_oe [*7]; endproperty
a_low: assert property (p_low) else $error("low phase short");
property p_high; $rose(dev_scl_oe) |-> $past(scl_line, 4); endproperty
a_high: assert property (p_high) else $error("high phase short");
property p_stop; $fell(dev_sda_oe) && scl_line |=> !dev_scl_oe [*8];
endproperty
a_stop: assert property (p_stop) else $error("clock after stop");
property p_hold; $fell(far_sda_oe) |-> dev_scl_oe [*8]; endproperty
a_hold: assert property (p_hold) else $error("clock not held");
sequence s_lost; bench_sda_low && scl_line && !dev_sda_oe; endsequence
property p_lost; s_lost |=> !dev_sda_oe; endproperty
a_lost: assert property (p_lost) else $error("loser drove data");
c_start: cover property ($rose(dev_sda_oe) && scl_line);
c_ack: cover property ($rose(far_sda_oe));
c_lost: cover property (s_lost ##1 sda_line);
endmodule

// ### tb/test_twowire_master_arbitration.sv
// bench: register sequences through master and peer on one link
`timescale 1ns/1ps
module test_twowire_master_arbitration;
logic ref_clk_in = 1'b0;
logic resetn_in = 1'b0;
logic [1:0] addr = 2'h0;
logic [7:0] wdata = 8'h00;
logic wr_s = 1'b0;
logic rd_s = 1'b0;
logic gie = 1'b0;
logic [7:0] rdata, rx_data, v;
logic irq, rx_valid, sel;
int n_errors = 0;
int total_checks = 0;
int cyc = 0;
always #12.5 ref_clk_in = ~ref_clk_in;
twm_bus_if twm_bus_if_i ();
twm_master #(.HALF_CYC(8), .OWN_ADDR(7'h00)) twm_master_i (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .global_irq_enable_in(gie), .irq_out(irq),
    .bus(twm_bus_if_i));
twm_peer twm_peer_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .selected_out(sel),
    .bus(twm_bus_if_i));
twm_monitor twm_monitor_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .scl_line(twm_bus_if_i.scl_line), .sda_line(twm_bus_if_i.sda_line),
    .dev_scl_oe(twm_bus_if_i.dev_scl_oe),
    .dev_sda_oe(twm_bus_if_i.dev_sda_oe),
    .far_sda_oe(twm_bus_if_i.far_sda_oe),
    .bench_sda_low(twm_bus_if_i.bench_sda_low));
////////////////////////////////////////////////////////////////////////////
task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask
task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk_in);
    wr_s <= 1'b0;
endtask
task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_in);
    rd_s <= 1'b0;
    @(posedge ref_clk_in);
    d = rdata;
endtask
// the pause after the flag keeps the held clock visible to the checker
task wait_flag;
    v = 8'h00;
    for (int i = 0; i < 400 && v[7] !== 1'b1; i++) rd(2'h0, v);
    chk({7'h00, v[7]}, 8'h01, "flag");
    repeat (16) @(posedge ref_clk_in);
endtask
task status(input logic [7:0] exp, input string what);
    rd(2'h1, v);
    chk(v, exp, what);
endtask
task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
        n_errors++;
        report_and_stop();
    end
end
////////////////////////////////////////////////////////////////////////////
initial begin
    twm_bus_if_i.bench_scl_low <= 1'b0;
    twm_bus_if_i.bench_sda_low <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    status(8'hf8, "status reset");
    rd(2'h3, v);
    chk(v, 8'h00, "unmapped");
    $display("test reset done");
    wr(2'h0, 8'ha4);
    wait_flag();
    status(8'h08, "start code");
    chk({7'h00, twm_bus_if_i.scl_line}, 8'h00, "scl held");
    wr(2'h0, 8'h05);
    gie <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    status(8'h08, "no action");
    chk({7'h00, irq}, 8'h01, "irq on");
    gie <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk({7'h00, irq}, 8'h00, "irq off");
    $display("test start done");
    wr(2'h2, 8'ha0);
    wr(2'h0, 8'h84);
    wait_flag();
    status(8'h18, "addr ack");
    chk({7'h00, sel}, 8'h01, "selected");
    rd(2'h2, v);
    chk(v, 8'ha0, "byte reg");
    $display("test address done");
    wr(2'h2, 8'h3c);
    wr(2'h0, 8'h84);
    repeat (20) @(posedge ref_clk_in);
    for (int i = 0; i < 100 && twm_bus_if_i.scl_line; i++)
        @(posedge ref_clk_in);
    twm_bus_if_i.bench_scl_low <= 1'b1;
    repeat (30) @(posedge ref_clk_in);
    twm_bus_if_i.bench_scl_low <= 1'b0;
    wait_flag();
    status(8'h28, "data ack");
    chk(rx_data, 8'h3c, "peer byte");
    $display("test data done");
    wr(2'h0, 8'h94);
    repeat (60) @(posedge ref_clk_in);
    rd(2'h0, v);
    chk({7'h00, v[7]}, 8'h00, "no flag");
    chk({6'h00, twm_bus_if_i.scl_line, twm_bus_if_i.sda_line}, 8'h03,
        "lines free");
    $display("test stop done");
    wr(2'h0, 8'ha4);
    wait_flag();
    wr(2'h2, 8'h22);
    wr(2'h0, 8'h84);
    wait_flag();
    status(8'h20, "addr nack");
    wr(2'h0, 8'ha4);
    wait_flag();
    status(8'h10, "repeat code");
    twm_bus_if_i.bench_sda_low <= 1'b1;
    wr(2'h2, 8'hff);
    wr(2'h0, 8'h84);
    wait_flag();
    status(8'h68, "lost code");
    chk({7'h00, twm_bus_if_i.dev_sda_oe}, 8'h00, "released");
    chk({7'h00, twm_bus_if_i.scl_line}, 8'h01, "slave mode");
    twm_bus_if_i.bench_sda_low <= 1'b0;
    wr(2'h0, 8'h80);
    $display("test arbitration done");
    report_and_stop();
end
endmodule
